// ==== verilog/status_params.svh ====
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

// register select codes on the command port
`define REG_OPERATION_SUMMARY_COND 4'h0
`define REG_OPERATION_SUMMARY_RISE 4'h1
`define REG_OPERATION_SUMMARY_FALL 4'h2
`define REG_OPERATION_SUMMARY_EVENT 4'h3
`define REG_OPERATION_SUMMARY_ENAB 4'h4
`define REG_ABNORMAL_SUMMARY_COND 4'h5
`define REG_ABNORMAL_SUMMARY_RISE 4'h6
`define REG_ABNORMAL_SUMMARY_FALL 4'h7
`define REG_ABNORMAL_SUMMARY_EVENT 4'h8
`define REG_ABNORMAL_SUMMARY_ENAB 4'h9
`define REG_STD_LATCH 4'ha
`define REG_STD_MASK 4'hb
`define REG_STATUS_BYTE 4'hc
`define REG_SRQ_MASK 4'hd
`define REG_POLL 4'he

// operation condition bit positions
`define OPERATION_SUMMARY_CAL_BIT 0
`define OPERATION_SUMMARY_WTG_BIT 5
`define OPERATION_SUMMARY_CV_BIT 8
`define OPERATION_SUMMARY_CV2_BIT 9
`define OPERATION_SUMMARY_CCP_BIT 10
`define OPERATION_SUMMARY_CCN_BIT 11
`define OPERATION_SUMMARY_CC2_BIT 12
`define OPERATION_SUMMARY_USED_MASK 16'h1f21

// questionable condition bit positions
`define ABNORMAL_SUMMARY_OV_BIT 0
`define ABNORMAL_SUMMARY_OCP_BIT 1
`define ABNORMAL_SUMMARY_FP_BIT 3
`define ABNORMAL_SUMMARY_OT_BIT 4
`define ABNORMAL_SUMMARY_OS_BIT 5
`define ABNORMAL_SUMMARY_SECOND_OUTPUT_UNREGULATED_BIT 8
`define ABNORMAL_SUMMARY_RI_BIT 9
`define ABNORMAL_SUMMARY_UNR_BIT 10
`define ABNORMAL_SUMMARY_OC2_BIT 12
`define ABNORMAL_SUMMARY_OVLD_BIT 14
`define ABNORMAL_SUMMARY_USED_MASK 16'h573b

// standard event bits
`define STD_OPC_BIT 0
`define STD_QYE_BIT 2
`define STD_DDE_BIT 3
`define STD_EXE_BIT 4
`define STD_CME_BIT 5
`define STD_PON_BIT 7
`define STD_USED_MASK 8'hbd

// status byte bits
`define SB_ABNORMAL_SUMMARY_BIT 3
`define SB_MAV_BIT 4
`define SB_ESB_BIT 5
`define SB_RQS_BIT 6
`define SB_OPERATION_SUMMARY_BIT 7

`define RESET_WORD16 16'h0000
`define RESET_BYTE 8'h00

`endif

// ==== verilog/status_pkg.sv ====
package status_pkg;

  typedef struct packed {
    logic low_range_overload;
    logic second_overcurrent_trip;
    logic main_output_unregulated;
    logic remote_inhibit_active;
    logic second_output_unregulated;
    logic open_sense_lead;
    logic overtemperature_trip;
    logic local_keypress;
    logic overcurrent_trip;
    logic overvoltage_trip;
  } abnormal_summary_cond_t;

  typedef struct packed {
    logic second_current_limit;
    logic negative_current_limit;
    logic positive_current_limit;
    logic second_voltage_regulating;
    logic main_voltage_regulating;
    logic awaiting_trigger;
    logic calibrating;
  } operation_summary_cond_t;

  typedef struct packed {
    logic command_error;
    logic execution_error;
    logic device_error;
    logic query_error;
    logic operation_complete;
  } std_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [15:0] wdata;
  } cmd_t;

endpackage

// ==== verilog/event_group.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "status_params.svh"

// condition -> transition filters -> latched event -> enabled summary
module event_group (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] condition,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_enab,
  input wire logic [15:0] wdata,
  input wire logic rd_event,
  output logic [15:0] rise_mask,
  output logic [15:0] fall_mask,
  output logic [15:0] event_bits,
  output logic [15:0] enable_mask,
  output logic summary
);
  logic [15:0] cond_prev;
  wire [15:0] rose = condition & ~cond_prev & rise_mask;
  wire [15:0] fell = ~condition & cond_prev & fall_mask;
  wire [15:0] hits = rose | fell;
  wire [15:0] kept = rd_event ? 16'h0000 : event_bits;
  wire [15:0] next_event = kept | hits;

  assign summary = |(event_bits & enable_mask);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cond_prev <= `RESET_WORD16;
      rise_mask <= `RESET_WORD16;
      fall_mask <= `RESET_WORD16;
      enable_mask <= `RESET_WORD16;
      event_bits <= `RESET_WORD16;
    end else begin
      cond_prev <= condition;
      event_bits <= next_event;
      if (wr_rise) rise_mask <= wdata;
      if (wr_fall) fall_mask <= wdata;
      if (wr_enab) enable_mask <= wdata;
    end
  end
endmodule // event_group

`default_nettype wire

// ==== verilog/status_reporting.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "status_params.svh"

module status_reporting (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_on,
  input wire logic power_on_clear_flag,
  input wire status_pkg::operation_summary_cond_t operation_summary_in,
  input wire status_pkg::abnormal_summary_cond_t abnormal_summary_in,
  input wire status_pkg::std_events_t std_in,
  input wire logic queue_not_empty,
  input wire status_pkg::cmd_t cmd,
  output logic [15:0] rdata,
  output logic service_request
);
  // two-stage synchronisers for circuit condition pins
  status_pkg::operation_summary_cond_t operation_summary_s1, operation_summary_s2;
  status_pkg::abnormal_summary_cond_t abnormal_summary_s1, abnormal_summary_s2;
  logic [15:0] operation_summary_cond;
  logic [15:0] abnormal_summary_cond;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      operation_summary_s1 <= '0;
      operation_summary_s2 <= '0;
      abnormal_summary_s1 <= '0;
      abnormal_summary_s2 <= '0;
    end else begin
      operation_summary_s1 <= operation_summary_in;
      operation_summary_s2 <= operation_summary_s1;
      abnormal_summary_s1 <= abnormal_summary_in;
      abnormal_summary_s2 <= abnormal_summary_s1;
    end
  end

  // map live conditions to documented bit positions; others zero
  always_comb begin
    operation_summary_cond = 16'h0000;
    operation_summary_cond[`OPERATION_SUMMARY_CAL_BIT] = operation_summary_s2.calibrating;
    operation_summary_cond[`OPERATION_SUMMARY_WTG_BIT] = operation_summary_s2.awaiting_trigger;
    operation_summary_cond[`OPERATION_SUMMARY_CV_BIT] = operation_summary_s2.main_voltage_regulating;
    operation_summary_cond[`OPERATION_SUMMARY_CV2_BIT] = operation_summary_s2.second_voltage_regulating;
    operation_summary_cond[`OPERATION_SUMMARY_CCP_BIT] = operation_summary_s2.positive_current_limit;
    operation_summary_cond[`OPERATION_SUMMARY_CCN_BIT] = operation_summary_s2.negative_current_limit;
    operation_summary_cond[`OPERATION_SUMMARY_CC2_BIT] = operation_summary_s2.second_current_limit;
  end

  always_comb begin
    abnormal_summary_cond = 16'h0000;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OV_BIT] = abnormal_summary_s2.overvoltage_trip;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OCP_BIT] = abnormal_summary_s2.overcurrent_trip;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_FP_BIT] = abnormal_summary_s2.local_keypress;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OT_BIT] = abnormal_summary_s2.overtemperature_trip;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OS_BIT] = abnormal_summary_s2.open_sense_lead;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_SECOND_OUTPUT_UNREGULATED_BIT] = abnormal_summary_s2.second_output_unregulated;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_RI_BIT] = abnormal_summary_s2.remote_inhibit_active;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_UNR_BIT] = abnormal_summary_s2.main_output_unregulated;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OC2_BIT] = abnormal_summary_s2.second_overcurrent_trip;
    abnormal_summary_cond[`ABNORMAL_SUMMARY_OVLD_BIT] = abnormal_summary_s2.low_range_overload;
  end

  function automatic logic hit(input status_pkg::cmd_t c, input logic [3:0] s);
    hit = c.sel == s;
  endfunction

  wire wr_operation_summary_rise = cmd.wr && hit(cmd, `REG_OPERATION_SUMMARY_RISE);
  wire wr_operation_summary_fall = cmd.wr && hit(cmd, `REG_OPERATION_SUMMARY_FALL);
  wire wr_operation_summary_enab = cmd.wr && hit(cmd, `REG_OPERATION_SUMMARY_ENAB);
  wire rd_operation_summary_event = cmd.rd && hit(cmd, `REG_OPERATION_SUMMARY_EVENT);
  wire wr_abnormal_summary_rise = cmd.wr && hit(cmd, `REG_ABNORMAL_SUMMARY_RISE);
  wire wr_abnormal_summary_fall = cmd.wr && hit(cmd, `REG_ABNORMAL_SUMMARY_FALL);
  wire wr_abnormal_summary_enab = cmd.wr && hit(cmd, `REG_ABNORMAL_SUMMARY_ENAB);
  wire rd_abnormal_summary_event = cmd.rd && hit(cmd, `REG_ABNORMAL_SUMMARY_EVENT);
  wire rd_std_latch = cmd.rd && hit(cmd, `REG_STD_LATCH);
  wire wr_std_mask = cmd.wr && hit(cmd, `REG_STD_MASK);
  wire wr_srq_mask = cmd.wr && hit(cmd, `REG_SRQ_MASK);
  wire rd_poll = cmd.rd && hit(cmd, `REG_POLL);

  logic [15:0] operation_summary_rise, operation_summary_fall, operation_summary_event, operation_summary_enab;
  logic [15:0] abnormal_summary_rise, abnormal_summary_fall, abnormal_summary_event, abnormal_summary_enab;
  logic operation_summary_summary, abnormal_summary;

  event_group operation_summary_group (
    .clk(clk),
    .nrst(nrst),
    .condition(operation_summary_cond & `OPERATION_SUMMARY_USED_MASK),
    .wr_rise(wr_operation_summary_rise),
    .wr_fall(wr_operation_summary_fall),
    .wr_enab(wr_operation_summary_enab),
    .wdata(cmd.wdata & `OPERATION_SUMMARY_USED_MASK),
    .rd_event(rd_operation_summary_event),
    .rise_mask(operation_summary_rise),
    .fall_mask(operation_summary_fall),
    .event_bits(operation_summary_event),
    .enable_mask(operation_summary_enab),
    .summary(operation_summary_summary)
  );

  event_group abnormal_summary_group (
    .clk(clk),
    .nrst(nrst),
    .condition(abnormal_summary_cond & `ABNORMAL_SUMMARY_USED_MASK),
    .wr_rise(wr_abnormal_summary_rise),
    .wr_fall(wr_abnormal_summary_fall),
    .wr_enab(wr_abnormal_summary_enab),
    .wdata(cmd.wdata & `ABNORMAL_SUMMARY_USED_MASK),
    .rd_event(rd_abnormal_summary_event),
    .rise_mask(abnormal_summary_rise),
    .fall_mask(abnormal_summary_fall),
    .event_bits(abnormal_summary_event),
    .enable_mask(abnormal_summary_enab),
    .summary(abnormal_summary)
  );

  // standard event group
  logic [7:0] std_latch;
  logic [7:0] std_mask;
  logic [7:0] srq_mask;
  logic rqs;
  logic pon_seen;
  logic [7:0] std_hits;

  always_comb begin
    std_hits = 8'h00;
    std_hits[`STD_OPC_BIT] = std_in.operation_complete;
    std_hits[`STD_QYE_BIT] = std_in.query_error;
    std_hits[`STD_DDE_BIT] = std_in.device_error;
    std_hits[`STD_EXE_BIT] = std_in.execution_error;
    std_hits[`STD_CME_BIT] = std_in.command_error;
    std_hits[`STD_PON_BIT] = power_on;
  end

  wire [7:0] std_kept = rd_std_latch ? 8'h00 : std_latch;
  wire [7:0] next_std_latch = (std_kept | std_hits) & `STD_USED_MASK;
  wire event_summary = |(std_latch & std_mask);

  // status byte without bit 6, which is filled per read kind
  wire [7:0] sb_base = {operation_summary_summary, 1'b0, event_summary, queue_not_empty,
                        abnormal_summary, 3'b000};
  wire master_summary = |(sb_base & srq_mask);
  wire next_rqs = master_summary | (rqs & ~rd_poll);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      std_latch <= `RESET_BYTE;
      srq_mask <= `RESET_BYTE;
      rqs <= 1'b0;
    end else begin
      std_latch <= next_std_latch;
      rqs <= next_rqs;
      if (wr_srq_mask) srq_mask <= cmd.wdata[7:0];
    end
  end

  // mask survives reset unless power-on clear flag asks otherwise
  always_ff @(posedge clk) begin
    if (wr_std_mask) std_mask <= cmd.wdata[7:0];
    else if (power_on && power_on_clear_flag) std_mask <= `RESET_BYTE;
  end

  assign service_request = rqs;

  // read data mux; condition reads live and ignore writes
  logic [15:0] next_rdata;
  always_comb begin
    case (cmd.sel)
      `REG_OPERATION_SUMMARY_COND: next_rdata = operation_summary_cond;
      `REG_OPERATION_SUMMARY_RISE: next_rdata = operation_summary_rise;
      `REG_OPERATION_SUMMARY_FALL: next_rdata = operation_summary_fall;
      `REG_OPERATION_SUMMARY_EVENT: next_rdata = operation_summary_event;
      `REG_OPERATION_SUMMARY_ENAB: next_rdata = operation_summary_enab;
      `REG_ABNORMAL_SUMMARY_COND: next_rdata = abnormal_summary_cond;
      `REG_ABNORMAL_SUMMARY_RISE: next_rdata = abnormal_summary_rise;
      `REG_ABNORMAL_SUMMARY_FALL: next_rdata = abnormal_summary_fall;
      `REG_ABNORMAL_SUMMARY_EVENT: next_rdata = abnormal_summary_event;
      `REG_ABNORMAL_SUMMARY_ENAB: next_rdata = abnormal_summary_enab;
      `REG_STD_LATCH: next_rdata = {8'h00, std_latch};
      `REG_STD_MASK: next_rdata = {8'h00, std_mask};
      `REG_STATUS_BYTE: next_rdata = {8'h00, sb_base | {1'b0, master_summary, 6'h00}};
      `REG_SRQ_MASK: next_rdata = {8'h00, srq_mask};
      `REG_POLL: next_rdata = {8'h00, sb_base | {1'b0, rqs, 6'h00}};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) rdata <= 16'h0000;
    else if (cmd.rd) rdata <= next_rdata;
  end
endmodule // status_reporting

`default_nettype wire

// ==== bench/status_bench_pkg.sv ====
package status_bench_pkg;
  function automatic logic [15:0] ow(status_pkg::operation_summary_cond_t c);
    return {3'b0, c[6:2], 2'b0, c[1], 4'b0, c[0]};
  endfunction
  function automatic logic [15:0] qw(status_pkg::abnormal_summary_cond_t c);
    return {1'b0, c[9], 1'b0, c[8], 1'b0, c[7:5], 2'b0, c[4:2], 1'b0, c[1:0]};
  endfunction
endpackage

// ==== bench/status_reporting_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_reporting_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_on,
  input wire logic power_on_clear_flag,
  input wire status_pkg::operation_summary_cond_t operation_summary_in,
  input wire status_pkg::abnormal_summary_cond_t abnormal_summary_in,
  input wire status_pkg::std_events_t std_in,
  input wire logic queue_not_empty,
  input wire status_pkg::cmd_t cmd,
  input wire logic [15:0] rdata,
  input wire logic service_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd = cmd.rd;
  wire [3:0] s = cmd.sel;
  a_operation_summary_live: assert property ((nrst && $stable(operation_summary_in))[*4] ##0 (rd && s == 4'h0)
    |=> rdata == status_bench_pkg::ow($past(operation_summary_in))) else $error("operation_summary cond");
  a_abnormal_summary_live: assert property ((nrst && $stable(abnormal_summary_in))[*4] ##0 (rd && s == 4'h5)
    |=> rdata == status_bench_pkg::qw($past(abnormal_summary_in))) else $error("abnormal_summary cond");
  a_poll_returns_rqs: assert property (rd && s == 4'he |=> rdata[6] == $past(service_request)) else $error("poll");
  a_request_held: assert property (service_request && !(rd && s == 4'he) |=> service_request) else $error("rqs");
  a_mav_bit: assert property (rd && s == 4'hc |=> rdata[4] == $past(queue_not_empty)) else $error("mav");
  a_byte_upper_zero: assert property (rd && s >= 4'ha |=> rdata[15:8] == 8'h00) else $error("upper");
  a_operation_summary_unused_zero: assert property (rd && s < 4'h5 |=> (rdata & 16'he0de) == 16'h0000) else $error("unused");
  a_power_on_bit: assert property (power_on ##2 (rd && s == 4'ha) |=> rdata[7]) else $error("pon");
  a_mask_cleared: assert property (power_on && power_on_clear_flag ##2 (rd && s == 4'hb)
    |=> rdata == 16'h0000) else $error("psc");
  c_request: cover property (service_request);
  c_poll: cover property (rd && s == 4'he && service_request);
  c_power: cover property (power_on ##2 rd);
endmodule // status_reporting_checker
bind status_reporting status_reporting_checker i_chk (.clk(clk), .nrst(nrst), .power_on(power_on),
  .power_on_clear_flag(power_on_clear_flag), .operation_summary_in(operation_summary_in), .abnormal_summary_in(abnormal_summary_in),
  .std_in(std_in), .queue_not_empty(queue_not_empty), .cmd(cmd), .rdata(rdata),
  .service_request(service_request));
`default_nettype wire

// ==== bench/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  output var status_pkg::cmd_t cmd,
  output var logic power_on_clear_flag,
  input wire logic [15:0] rdata
);
  initial begin
    cmd = '0;
    power_on_clear_flag = 1'b1;
  end
  task automatic wr(input logic [3:0] sel, input logic [15:0] v);
    @(posedge clk);
    cmd <= '{1'b1, 1'b0, sel, v};
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic rd(input logic [3:0] sel, output logic [15:0] v);
    @(posedge clk);
    cmd <= '{1'b0, 1'b1, sel, 16'h0000};
    @(posedge clk);
    cmd <= '0;
    #1 v = rdata;
  endtask
  task automatic set_flag(input logic f);
    @(posedge clk);
    power_on_clear_flag <= f;
  endtask
  // power-on raises a service request; std mask kept across power-on
  task automatic arm();
    @(posedge clk);
    power_on_clear_flag <= 1'b0;
    wr(4'hb, 16'h0080);
    wr(4'hd, 16'h0020);
  endtask
endmodule // host_model
`default_nettype wire

// ==== bench/test_status_reporting.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_status_reporting;
  logic clk, nrst, power_on, queue_not_empty, power_on_clear_flag, service_request;
  status_pkg::operation_summary_cond_t operation_summary_in;
  status_pkg::abnormal_summary_cond_t abnormal_summary_in;
  status_pkg::std_events_t std_in;
  status_pkg::cmd_t cmd;
  logic [15:0] rdata, d, q;
  int err_total, cmp_count;
  logic [3:0] rs [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9};
  logic [15:0] rm [6] = '{16'h1f21, 16'h1f21, 16'h1f21, 16'h573b, 16'h573b, 16'h573b};
  logic [6:0] op [3] = '{7'h7f, 7'h55, 7'h2a};
  logic [9:0] qp [3] = '{10'h3ff, 10'h155, 10'h2aa};
  host_model i_host (.clk(clk), .cmd(cmd), .power_on_clear_flag(power_on_clear_flag),
    .rdata(rdata));
  status_reporting i_dut (.clk(clk), .nrst(nrst), .power_on(power_on),
    .power_on_clear_flag(power_on_clear_flag), .operation_summary_in(operation_summary_in), .abnormal_summary_in(abnormal_summary_in),
    .std_in(std_in), .queue_not_empty(queue_not_empty), .cmd(cmd), .rdata(rdata),
    .service_request(service_request));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] sel, input logic [15:0] exp);
    i_host.rd(sel, d);
    check(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse_power();
    @(posedge clk);
    power_on <= 1'b1;
    @(posedge clk);
    power_on <= 1'b0;
  endtask
  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    power_on = 1'b0;
    queue_not_empty = 1'b0;
    operation_summary_in = '0;
    abnormal_summary_in = '0;
    std_in = '0;
    err_total = 0;
    cmp_count = 0;
    cyc(20);
    nrst <= 1'b1;
    i_host.wr(4'hb, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      rchk(rs[i], 16'h0000);
      i_host.wr(rs[i], 16'hffff);
      rchk(rs[i], rm[i]);
      i_host.wr(rs[i], 16'h0000);
    end
    rchk(4'hd, 16'h0000);
    i_host.wr(4'hd, 16'hffff);
    rchk(4'hd, 16'h00ff);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      operation_summary_in <= op[k];
      abnormal_summary_in <= qp[k];
      cyc(3);
      rchk(4'h0, status_bench_pkg::ow(op[k]));
      i_host.wr(4'h0, 16'h0000);
      rchk(4'h0, status_bench_pkg::ow(op[k]));
      rchk(4'h5, status_bench_pkg::qw(qp[k]));
    end
    @(posedge clk);
    operation_summary_in <= '0;
    abnormal_summary_in <= '0;
    i_host.wr(4'h1, 16'h0400);
    i_host.wr(4'h2, 16'h0400);
    i_host.wr(4'h4, 16'h0400);
    i_host.wr(4'hd, 16'h0088);
    rchk(4'h3, 16'h0000);
    @(posedge clk);
    operation_summary_in <= 7'h10;
    cyc(6);
    check({15'h0, service_request}, 16'h0001);
    rchk(4'hc, 16'h00c0);
    rchk(4'h3, 16'h0400);
    rchk(4'h3, 16'h0000);
    rchk(4'hc, 16'h0000);
    i_host.rd(4'he, d);
    check({15'h0, d[6]}, 16'h0001);
    check({15'h0, service_request}, 16'h0000);
    @(posedge clk);
    operation_summary_in <= '0;
    cyc(6);
    rchk(4'h3, 16'h0400);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      operation_summary_in <= operation_summary_in ^ 7'h10;
      cyc(k);
      i_host.rd(4'h3, q);
      cyc(6);
      i_host.rd(4'h3, d);
      check(q | d, 16'h0400);
    end
    i_host.wr(4'h6, 16'h0013);
    i_host.wr(4'h9, 16'h0013);
    @(posedge clk);
    abnormal_summary_in <= 10'h001;
    cyc(6);
    rchk(4'hc, 16'h0048);
    rchk(4'h8, 16'h0001);
    i_host.wr(4'h9, 16'h0000);
    @(posedge clk);
    abnormal_summary_in <= 10'h003;
    cyc(6);
    rchk(4'hc, 16'h0000);
    rchk(4'h8, 16'h0002);
    @(posedge clk);
    std_in <= 5'h1f;
    @(posedge clk);
    std_in <= '0;
    rchk(4'ha, 16'h003d);
    rchk(4'ha, 16'h0000);
    i_host.rd(4'he, d);
    check({15'h0, service_request}, 16'h0000);
    i_host.arm();
    pulse_power();
    rchk(4'ha, 16'h0080);
    check({15'h0, service_request}, 16'h0001);
    rchk(4'hb, 16'h0080);
    i_host.set_flag(1'b1);
    pulse_power();
    rchk(4'hb, 16'h0000);
    rchk(4'ha, 16'h0080);
    i_host.wr(4'hb, 16'h0080);
    @(posedge clk);
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    rchk(4'hb, 16'h0080);
    @(posedge clk);
    queue_not_empty <= 1'b1;
    rchk(4'hc, 16'h0010);
    i_host.wr(4'hd, 16'h0010);
    rchk(4'hc, 16'h0050);
    cyc(2);
    check({15'h0, service_request}, 16'h0001);
    rchk(4'hf, 16'h0000);
    test_done();
  end
endmodule // test_status_reporting
`default_nettype wire
